// ===== hw/buck_ctrl_pkg.sv
// constants, types and helpers shared by the buck regulator control logic
// assumes one 250 MHz core clock and a synchronous active-low reset
// How it works
// R1 - debounced overvoltage sets status three bit two
// R2 - interrupt pin low only when mask clear
// R3 - overvoltage must persist 122 us first
// R4 - no overvoltage flag during start-up sequence
// R5 - live overvoltage sense bit separate from flag
// R6 - input undervoltage turns off external pass gate
// R7 - mode codes off, pwm, pfm, aps; aps reset
// R8 - regulators power up in auto pulse skip
// R9 - soft-start pfm, aps, pwm; selected mode 3ms later
// R10 - mode field may change anytime while on
// R11 - set points are 5, 3, 4 bit fields
// R12 - target moves 25 mV every 4 us
// R13 - software masks overcurrent while stepping, prefers pwm
// R14 - phase field selects 0, 90, 180, 270 degrees
// R15 - phase defaults 0, 90, 180 degrees per regulator
// R16 - frequency field 1, 2 default, 4 MHz
// R17 - phase and frequency chosen independently
// R18 - software picks optimum phasing for mixed frequencies
// R19 - first regulator code n is 0.7V+n*25mV, fixed tops
// R20 - reserved frequency keeps previous; steps from trimmed clock
package buck_ctrl_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS        = 4;
    localparam int OV_DEBOUNCE_NS       = 122000;
    localparam int MODE_HOLD_NS         = 3000000;
    localparam int STEP_INTERVAL_NS     = 4000;
    // least times round up
    localparam int OV_DEBOUNCE_CYCLES   = (OV_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_HOLD_CYCLES     = (MODE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_INTERVAL_CYCLES = STEP_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int SS_PHASE_CYCLES      = STEP_INTERVAL_CYCLES;

    // ************************************************************
    // field encodings and reset values
    // ************************************************************
    localparam logic [3:0] MODE_CODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CODE_PWM = 4'h1;
    localparam logic [3:0] MODE_CODE_PFM = 4'h3;
    localparam logic [3:0] MODE_CODE_APS = 4'h8;
    localparam logic [1:0] FREQ_1MHZ     = 2'h0;
    localparam logic [1:0] FREQ_2MHZ     = 2'h1;
    localparam logic [1:0] FREQ_4MHZ     = 2'h2;
    localparam logic [1:0] FREQ_RSVD     = 2'h3;
    localparam logic [1:0] FREQ_RESET    = FREQ_2MHZ;
    localparam logic [1:0] PHASE_0       = 2'h0;
    localparam logic [1:0] PHASE_90      = 2'h1;
    localparam logic [1:0] PHASE_180     = 2'h2;
    localparam logic [1:0] PHASE_270     = 2'h3;
    localparam logic [1:0] PHASE_RESET_A = PHASE_0;
    localparam logic [1:0] PHASE_RESET_B = PHASE_90;
    localparam logic [1:0] PHASE_RESET_C = PHASE_180;
    localparam int         OVP_IRQ_BIT   = 2;
    localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;

    // ************************************************************
    // set point scaling in millivolts
    // ************************************************************
    localparam logic [11:0] STEP_MV      = 12'h019;
    localparam logic [11:0] A_BASE_MV    = 12'h2bc;
    localparam logic [4:0]  A_CODE_1V8   = 5'h1e;
    localparam logic [4:0]  A_CODE_3V3   = 5'h1f;
    localparam logic [11:0] A_FIXED_1V8  = 12'h708;
    localparam logic [11:0] A_FIXED_3V3  = 12'hce4;
    localparam logic [11:0] B_LOW_BASE_MV = 12'h5dc;
    localparam logic [11:0] BC_STEP_MV   = 12'h032;
    localparam logic [11:0] C_BASE_MV    = 12'h384;

    typedef enum logic [1:0] {SW_OFF, SW_PWM, SW_PFM, SW_APS} sw_mode_t;
    typedef enum logic [2:0] {ST_OFF, ST_SS_PFM, ST_SS_APS, ST_SS_PWM, ST_HOLD, ST_RUN} seq_state_t;

    // illegal mode codes keep the previous mode
    function automatic sw_mode_t mode_decode(input logic [3:0] code, input sw_mode_t prev);
        unique case (code)
            MODE_CODE_OFF: mode_decode = SW_OFF;
            MODE_CODE_PWM: mode_decode = SW_PWM;
            MODE_CODE_PFM: mode_decode = SW_PFM;
            MODE_CODE_APS: mode_decode = SW_APS;
            default:       mode_decode = prev;
        endcase
    endfunction

    function automatic logic [11:0] a_setpoint_mv(input logic [4:0] code);
        if (code == A_CODE_1V8) begin
            a_setpoint_mv = A_FIXED_1V8;
        end else if (code == A_CODE_3V3) begin
            a_setpoint_mv = A_FIXED_3V3;
        end else begin
            a_setpoint_mv = A_BASE_MV + 12'(code) * STEP_MV;
        end
    endfunction

    // high range table is irregular, so it is a lookup
    function automatic logic [11:0] b_setpoint_mv(input logic [2:0] code, input logic high);
        if (!high) begin
            b_setpoint_mv = B_LOW_BASE_MV + 12'(code) * BC_STEP_MV;
        end else begin
            unique case (code)
                3'h0: b_setpoint_mv = 12'h9c4;
                3'h1: b_setpoint_mv = 12'haf0;
                3'h2: b_setpoint_mv = 12'hb22;
                3'h3: b_setpoint_mv = 12'hbb8;
                3'h4: b_setpoint_mv = 12'hc1c;
                3'h5: b_setpoint_mv = 12'hc4e;
                3'h6: b_setpoint_mv = 12'hc80;
                3'h7: b_setpoint_mv = 12'hce4;
            endcase
        end
    endfunction

    function automatic logic [11:0] step_toward(input logic [11:0] cur, input logic [11:0] tgt);
        if (tgt > cur) begin
            step_toward = ((tgt - cur) > STEP_MV) ? cur + STEP_MV : tgt;
        end else begin
            step_toward = ((cur - tgt) > STEP_MV) ? cur - STEP_MV : tgt;
        end
    endfunction

endpackage

// ===== hw/buck_channel.sv
// one buck regulator: mode sequencing, voltage stepping, phase and frequency
// assumes control fields come from register logic on core_clk
`timescale 1ns/1ps
module buck_channel
    import buck_ctrl_pkg::*;
#(
    parameter logic [1:0] PHASE_RESET = PHASE_0,
    parameter int         HOLD_CYCLES = MODE_HOLD_CYCLES
) (
    input  logic        core_clk,
    input  logic        nrst,
    input  logic        turn_on,
    input  logic        in_regulation,
    input  logic [3:0]  mode_field,
    input  logic [1:0]  phase_field,
    input  logic [1:0]  freq_field,
    input  logic [11:0] setpoint_mv,
    output sw_mode_t    active_mode,
    output logic [1:0]  phase_sel,
    output logic [1:0]  freq_sel,
    output logic [11:0] target_mv,
    output logic        voltage_stepping
);
    seq_state_t  state;
    sw_mode_t    selected_mode;
    logic [19:0] seq_count;
    logic [9:0]  step_count;
    logic        reg_meta;
    logic        reg_sync;

    // regulation comparator is analog, so synchronise it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_meta <= 1'b0;
            reg_sync <= 1'b0;
        end else begin
            reg_meta <= in_regulation;
            reg_sync <= reg_meta;
        end
    end

    // soft-start walk, then hold before handing over to the field
    always_ff @(posedge core_clk) begin
        if (!nrst || !turn_on) begin
            state     <= ST_OFF;
            seq_count <= 20'h00000;
        end else begin
            unique case (state)
                ST_OFF: begin
                    state <= ST_SS_PFM; // [R9]
                end
                ST_SS_PFM, ST_SS_APS: begin
                    if (seq_count == 20'(SS_PHASE_CYCLES - 1)) begin
                        state     <= (state == ST_SS_PFM) ? ST_SS_APS : ST_SS_PWM; // [R9]
                        seq_count <= 20'h00000;
                    end else begin
                        seq_count <= seq_count + 20'h00001;
                    end
                end
                ST_SS_PWM: begin
                    if (reg_sync) begin
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (seq_count == 20'(HOLD_CYCLES - 1)) begin
                        state <= ST_RUN; // [R9]
                    end else begin
                        seq_count <= seq_count + 20'h00001;
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // the field is tracked at all times, aps after reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            selected_mode <= SW_APS; // [R7] [R8]
        end else begin
            selected_mode <= mode_decode(mode_field, selected_mode); // [R7] [R10]
        end
    end

    // what the power stage actually runs in
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            active_mode <= SW_OFF;
        end else begin
            unique case (state)
                ST_OFF:             active_mode <= SW_OFF;
                ST_SS_PFM:          active_mode <= SW_PFM; // [R9]
                ST_SS_APS:          active_mode <= SW_APS; // [R8] [R9]
                ST_SS_PWM, ST_HOLD: active_mode <= SW_PWM; // [R9]
                ST_RUN:             active_mode <= selected_mode; // [R10]
            endcase
        end
    end

    // phase and frequency are separate registers, any pairing allowed
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            phase_sel <= PHASE_RESET; // [R15]
            freq_sel  <= FREQ_RESET; // [R16]
        end else begin
            phase_sel <= phase_field; // [R14] [R17]
            if (freq_field != FREQ_RSVD) begin
                freq_sel <= freq_field; // [R16] [R20]
            end
        end
    end

    // stepping interval counted on the trimmed core clock
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            target_mv  <= 12'h000;
            step_count <= 10'h000;
        end else if (state == ST_OFF || target_mv == setpoint_mv) begin
            target_mv  <= setpoint_mv;
            step_count <= 10'h000;
        end else if (step_count == 10'(STEP_INTERVAL_CYCLES - 1)) begin
            target_mv  <= step_toward(target_mv, setpoint_mv); // [R12] [R20]
            step_count <= 10'h000;
        end else begin
            step_count <= step_count + 10'h001;
        end
    end

    // lets software mask overcurrent for the whole transition
    assign voltage_stepping = (target_mv != setpoint_mv); // [R13]

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    freq_reserved_a: assert property ( // [R20]
        freq_field == FREQ_RSVD |=> $stable(freq_sel))
        else $error("reserved frequency code changed the selection");
    freq_follow_a: assert property ( // [R16]
        freq_field != FREQ_RSVD |=> freq_sel == $past(freq_field))
        else $error("frequency selection did not follow the field");
    step_timing_a: assert property ( // [R12]
        $past(state) != ST_OFF && state != ST_OFF && target_mv != $past(target_mv)
        |-> $past(step_count) == 10'(STEP_INTERVAL_CYCLES - 1))
        else $error("voltage target moved off the step interval");
    ss_order_a: assert property ( // [R9]
        state == ST_SS_APS |=> state inside {ST_SS_APS, ST_SS_PWM, ST_OFF})
        else $error("soft-start left aps for a wrong state");
    run_mode_a: assert property ( // [R10]
        state == ST_RUN && turn_on && mode_field == MODE_CODE_PWM ##1 turn_on
        |=> active_mode == SW_PWM)
        else $error("pwm field not applied in run");
    step_cover: cover property (voltage_stepping ##1 !voltage_stepping);
endmodule

// ===== hw/buck_ctrl.sv
// top of the buck regulator control: front-end supervision and three channels
// assumes pins arrive asynchronously; fields and strobes come on core_clk
`timescale 1ns/1ps
module buck_ctrl
    import buck_ctrl_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = OV_DEBOUNCE_CYCLES,
    parameter int HOLD_CYCLES     = MODE_HOLD_CYCLES
) (
    input  logic        core_clk,
    input  logic        nrst,
    // front end
    input  logic        front_supply_pin,
    input  logic        main_input_rail_low,
    input  logic        startup_busy,
    input  logic        ovp_mask,
    input  logic [7:0]  irq_status_clear,
    output logic        irq_out_n,
    output logic [7:0]  irq_status_three,
    output logic        ovp_irq,
    output logic        ovp_sense,
    output logic        gate_enable,
    // first regulator
    input  logic        buck_a_on,
    input  logic        buck_a_in_reg,
    input  logic [3:0]  buck_a_mode_field,
    input  logic [1:0]  buck_a_phase_field,
    input  logic [1:0]  buck_a_freq_field,
    input  logic [4:0]  buck_a_setpoint,
    output sw_mode_t    buck_a_mode,
    output logic [1:0]  buck_a_phase,
    output logic [1:0]  buck_a_freq,
    output logic [11:0] buck_a_target_mv,
    output logic        buck_a_stepping,
    // second regulator
    input  logic        buck_b_on,
    input  logic        buck_b_in_reg,
    input  logic        buck_b_high_range,
    input  logic [3:0]  buck_b_mode_field,
    input  logic [1:0]  buck_b_phase_field,
    input  logic [1:0]  buck_b_freq_field,
    input  logic [2:0]  buck_b_setpoint,
    output sw_mode_t    buck_b_mode,
    output logic [1:0]  buck_b_phase,
    output logic [1:0]  buck_b_freq,
    output logic [11:0] buck_b_target_mv,
    output logic        buck_b_stepping,
    // third regulator
    input  logic        buck_c_on,
    input  logic        buck_c_in_reg,
    input  logic [3:0]  buck_c_mode_field,
    input  logic [1:0]  buck_c_phase_field,
    input  logic [1:0]  buck_c_freq_field,
    input  logic [3:0]  buck_c_setpoint,
    output sw_mode_t    buck_c_mode,
    output logic [1:0]  buck_c_phase,
    output logic [1:0]  buck_c_freq,
    output logic [11:0] buck_c_target_mv,
    output logic        buck_c_stepping
);
    // ************************************************************
    // front-end supervision
    // ************************************************************
    logic        ov_meta;
    logic        ov_sync;
    logic        uv_meta;
    logic        uv_sync;
    logic [14:0] ov_count;
    logic        ov_event;
    logic        ovp_set;
    logic [11:0] a_set_mv;
    logic [11:0] b_set_mv;
    logic [11:0] c_set_mv;

    // comparator outputs are asynchronous to the core clock
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ov_meta <= 1'b0;
            ov_sync <= 1'b0;
            uv_meta <= 1'b0;
            uv_sync <= 1'b0;
        end else begin
            ov_meta <= front_supply_pin;
            ov_sync <= ov_meta;
            uv_meta <= main_input_rail_low;
            uv_sync <= uv_meta;
        end
    end

    // live condition, unfiltered apart from synchronising
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ovp_sense <= 1'b0;
        end else begin
            ovp_sense <= ov_sync; // [R5]
        end
    end

    // counter saturates so one long overvoltage gives one event;
    // any dropout restarts the full interval
    always_ff @(posedge core_clk) begin
        if (!nrst || !ov_sync) begin
            ov_count <= 15'h0000;
        end else if (ov_count != 15'(DEBOUNCE_CYCLES)) begin
            ov_count <= ov_count + 15'h0001; // [R3]
        end
    end

    assign ov_event = ov_sync && (ov_count == 15'(DEBOUNCE_CYCLES - 1)); // [R3]
    // events while the sequencer still powers up are dropped
    assign ovp_set  = ov_event && !startup_busy; // [R4]

    // sticky flag; a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ovp_irq <= IRQ_STATUS_RESET[OVP_IRQ_BIT];
        end else begin
            ovp_irq <= ovp_set || (ovp_irq && !irq_status_clear[OVP_IRQ_BIT]); // [R1]
        end
    end

    // other bits of the register belong to other blocks and read zero here
    always_comb begin
        irq_status_three              = IRQ_STATUS_RESET;
        irq_status_three[OVP_IRQ_BIT] = ovp_irq; // [R1]
    end

    // open-drain style pin, released while masked
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= !(ovp_irq && !ovp_mask); // [R2]
        end
    end

    // pass gate held off in reset, a choice that favours a safe start
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            gate_enable <= 1'b0;
        end else begin
            gate_enable <= !uv_sync; // [R6]
        end
    end

    // ************************************************************
    // regulators
    // ************************************************************

    // set points scaled to millivolts for the stepper
    assign a_set_mv = a_setpoint_mv(buck_a_setpoint); // [R11] [R19]
    assign b_set_mv = b_setpoint_mv(buck_b_setpoint, buck_b_high_range); // [R11]
    assign c_set_mv = C_BASE_MV + 12'(buck_c_setpoint) * BC_STEP_MV; // [R11]

    buck_channel #(
        .PHASE_RESET (PHASE_RESET_A),
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_buck_a (
        .core_clk         (core_clk),
        .nrst             (nrst),
        .turn_on          (buck_a_on),
        .in_regulation    (buck_a_in_reg),
        .mode_field       (buck_a_mode_field),
        .phase_field      (buck_a_phase_field),
        .freq_field       (buck_a_freq_field),
        .setpoint_mv      (a_set_mv),
        .active_mode      (buck_a_mode),
        .phase_sel        (buck_a_phase),
        .freq_sel         (buck_a_freq),
        .target_mv        (buck_a_target_mv),
        .voltage_stepping (buck_a_stepping)
    );

    buck_channel #(
        .PHASE_RESET (PHASE_RESET_B),
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_buck_b (
        .core_clk         (core_clk),
        .nrst             (nrst),
        .turn_on          (buck_b_on),
        .in_regulation    (buck_b_in_reg),
        .mode_field       (buck_b_mode_field),
        .phase_field      (buck_b_phase_field),
        .freq_field       (buck_b_freq_field),
        .setpoint_mv      (b_set_mv),
        .active_mode      (buck_b_mode),
        .phase_sel        (buck_b_phase),
        .freq_sel         (buck_b_freq),
        .target_mv        (buck_b_target_mv),
        .voltage_stepping (buck_b_stepping)
    );

    buck_channel #(
        .PHASE_RESET (PHASE_RESET_C),
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_buck_c (
        .core_clk         (core_clk),
        .nrst             (nrst),
        .turn_on          (buck_c_on),
        .in_regulation    (buck_c_in_reg),
        .mode_field       (buck_c_mode_field),
        .phase_field      (buck_c_phase_field),
        .freq_field       (buck_c_freq_field),
        .setpoint_mv      (c_set_mv),
        .active_mode      (buck_c_mode),
        .phase_sel        (buck_c_phase),
        .freq_sel         (buck_c_freq),
        .target_mv        (buck_c_target_mv),
        .voltage_stepping (buck_c_stepping)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    ovp_flag_set_a: assert property ( // [R1]
        ovp_set |=> ovp_irq && irq_status_three[OVP_IRQ_BIT])
        else $error("debounced overvoltage did not set the flag");
    set_beats_clear_a: assert property ( // [R1]
        ovp_set && irq_status_clear[OVP_IRQ_BIT] |=> ovp_irq)
        else $error("clear in the event cycle lost the flag");
    irq_pin_low_a: assert property ( // [R2]
        ovp_irq && !ovp_mask |=> !irq_out_n)
        else $error("pending unmasked flag did not pull the pin low");
    irq_pin_masked_a: assert property ( // [R2]
        ovp_mask |=> irq_out_n)
        else $error("interrupt pin low while masked");
    debounce_len_a: assert property ( // [R3]
        $rose(ovp_irq) |-> ov_count == 15'(DEBOUNCE_CYCLES) && $past(ov_sync))
        else $error("flag raised before the debounce interval");
    startup_drop_a: assert property ( // [R4]
        ov_event && startup_busy && !ovp_irq |=> !ovp_irq)
        else $error("overvoltage flagged during start-up");
    sense_path_a: assert property ( // [R5]
        $rose(front_supply_pin) |-> ##3 ovp_sense)
        else $error("sense bit did not follow the supply pin");
    gate_off_a: assert property ( // [R6]
        main_input_rail_low |-> ##3 !gate_enable)
        else $error("pass gate stayed on during input droop");
    phase_reset_a: assert property ( // [R15]
        $rose(nrst) |-> buck_a_phase == PHASE_0 && buck_b_phase == PHASE_90
        && buck_c_phase == PHASE_180)
        else $error("phase defaults wrong after reset");

    ovp_raise_c: cover property ($rose(ovp_irq) ##1 !irq_out_n);
    ovp_startup_c: cover property (ov_event && startup_busy);
    droop_c: cover property ($fell(gate_enable));
    rsvd_freq_c: cover property (buck_a_freq_field == FREQ_RSVD ##1 buck_a_freq == FREQ_2MHZ);
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the buck regulator control top
// assumes short debounce and hold parameters; all three channels share one set of fields
`timescale 1ns/1ps
module tb_top
    import buck_ctrl_pkg::*;
;
    localparam int D = 8;
    localparam int H = 16;
    typedef struct {logic [1:0] ph, fq, eph, efq; logic [4:0] sp; logic [11:0] emv;} row_t;
    // ************************************************************
    // stimulus tables and signals
    // ************************************************************
    // reserved frequency rows expect the previous code to stay; phases mix per pairing
    row_t rows[8] = '{'{2'h0, 2'h0, 2'h0, 2'h0, 5'h00, 12'h2bc},
        '{2'h1, 2'h1, 2'h1, 2'h1, 5'h01, 12'h2d5}, '{2'h2, 2'h2, 2'h2, 2'h2, 5'h0c, 12'h3e8},
        '{2'h3, 2'h3, 2'h3, 2'h2, 5'h1d, 12'h591}, '{2'h3, 2'h0, 2'h3, 2'h0, 5'h1e, 12'h708},
        '{2'h0, 2'h3, 2'h0, 2'h0, 5'h1f, 12'hce4}, '{2'h2, 2'h1, 2'h2, 2'h1, 5'h10, 12'h44c},
        '{2'h1, 2'h2, 2'h1, 2'h2, 5'h1c, 12'h578}};
    logic [3:0] mc[5] = '{4'h0, 4'h1, 4'h3, 4'h8, 4'h5};
    sw_mode_t   me[5] = '{SW_OFF, SW_PWM, SW_PFM, SW_APS, SW_APS};
    logic       core_clk = 0, nrst = 0, pin = 0, uv = 0, busy = 0, mask = 0, on = 0, inr = 0;
    logic [7:0] clr = 8'h00;
    logic [3:0] md  = 4'h8;
    logic [1:0] ph  = 2'h0, fq = 2'h1;
    logic [4:0] sp  = 5'h00;
    logic       irq_n, ovi, ovs, gate, stp, bs, cs;
    logic [7:0] st;
    sw_mode_t   am, bm, cm;
    logic [1:0] ap, bp, cp, af, bf, cf;
    logic [11:0] at, bt, ct;
    int         fail_count = 0, total_checks = 0;

    buck_ctrl #(.DEBOUNCE_CYCLES(D), .HOLD_CYCLES(H)) u_dut (
        .core_clk(core_clk), .nrst(nrst), .front_supply_pin(pin), .main_input_rail_low(uv),
        .startup_busy(busy), .ovp_mask(mask), .irq_status_clear(clr), .irq_out_n(irq_n),
        .irq_status_three(st), .ovp_irq(ovi), .ovp_sense(ovs), .gate_enable(gate),
        .buck_a_on(on), .buck_a_in_reg(inr), .buck_a_mode_field(md), .buck_a_phase_field(ph),
        .buck_a_freq_field(fq), .buck_a_setpoint(sp), .buck_a_mode(am), .buck_a_phase(ap),
        .buck_a_freq(af), .buck_a_target_mv(at), .buck_a_stepping(stp),
        .buck_b_on(on), .buck_b_in_reg(inr), .buck_b_high_range(1'b0), .buck_b_mode_field(md),
        .buck_b_phase_field(ph), .buck_b_freq_field(fq), .buck_b_setpoint(sp[2:0]),
        .buck_b_mode(bm), .buck_b_phase(bp), .buck_b_freq(bf), .buck_b_target_mv(bt),
        .buck_b_stepping(bs), .buck_c_on(on), .buck_c_in_reg(inr), .buck_c_mode_field(md),
        .buck_c_phase_field(ph), .buck_c_freq_field(fq), .buck_c_setpoint(sp[3:0]),
        .buck_c_mode(cm), .buck_c_phase(cp), .buck_c_freq(cf), .buck_c_target_mv(ct),
        .buck_c_stepping(cs));

    // ************************************************************
    // helpers
    // ************************************************************
    // 4 ns clock
    always #2 core_clk = ~core_clk;
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // watchdog: the sequence needs about 3200 cycles, so 25000 means a hang
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    // checks land 1 ns after an edge so that edge's updates have settled
    initial begin
        tk(2); #1;
        chk(irq_n, 1); chk(st, 8'h00); chk(am, SW_OFF);
        chk(ap, PHASE_0); chk(bp, PHASE_90); chk(cp, PHASE_180);
        chk(af, FREQ_2MHZ);
        tk(1); nrst <= 1;
        tk(4); #1; chk(gate, 1);
        $display("reset test done");
        foreach (rows[i]) begin
            tk(1); ph <= rows[i].ph; fq <= rows[i].fq; sp <= rows[i].sp;
            tk(2); #1;
            chk(ap, rows[i].eph); chk(cp, rows[i].eph);
            chk(af, rows[i].efq); chk(cf, rows[i].efq);
            chk(bf, rows[i].efq);
            chk(at, rows[i].emv);
            chk(bt, 12'(1500 + 50 * sp[2:0])); chk(ct, 12'(900 + 50 * sp[3:0]));
        end
        $display("field table done");
        tk(1); uv <= 1; tk(4); #1; chk(gate, 0);
        tk(1); uv <= 0; tk(4); #1; chk(gate, 1);
        // a short spike must not count, the restart must
        tk(1); pin <= 1; tk(D - 2); pin <= 0; tk(1); pin <= 1;
        tk(D); #1; chk(ovi, 0); chk(ovs, 1);
        tk(2); #1; chk(ovi, 1); chk(st, 8'h04);
        tk(1); #1; chk(irq_n, 0);
        tk(1); mask <= 1; tk(2); #1; chk(irq_n, 1);
        tk(1); mask <= 0; clr <= 8'h04; tk(1); clr <= 8'h00;
        tk(2); #1; chk(ovi, 0); chk(ovs, 1);
        tk(1); pin <= 0; tk(4); #1; chk(ovs, 0);
        tk(1); busy <= 1; pin <= 1; tk(D + 8); #1; chk(ovi, 0); chk(irq_n, 1);
        tk(1); pin <= 0; busy <= 0;
        // clear strobe lands in the event cycle, the set must win
        tk(2); pin <= 1; tk(9); clr <= 8'h04; tk(1); clr <= 8'h00;
        #1; chk(ovi, 1);
        $display("overvoltage test done");
        tk(1); md <= 4'h3; on <= 1;
        tk(3); #1; chk(am, SW_PFM);
        tk(1001); #1; chk(am, SW_APS);
        tk(1000); #1; chk(am, SW_PWM);
        tk(1); inr <= 1; tk(H); #1; chk(am, SW_PWM);
        tk(10); #1; chk(am, SW_PFM);
        foreach (mc[i]) begin
            tk(1); md <= mc[i]; tk(3); #1; chk(am, me[i]);
            chk(bm, me[i]); chk(cm, me[i]);
        end
        $display("mode test done");
        tk(1); sp <= 5'h1e; tk(1); #1; chk(stp, 1); chk(at, 12'h578);
        chk(bs, 1); chk(cs, 1);
        tk(998); #1; chk(at, 12'h578);
        tk(3); #1; chk(at, 12'h591);
        tk(1); sp <= 5'h1d; tk(1); #1; chk(stp, 0);
        $display("stepping test done");
        end_sim();
    end
endmodule
